// ===== verilog/apes_host.v
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "apes_defs.vh"
// Functional notes
// RULE1: The programming supply is raised to its high level before a program or erase setup write.
// RULE2: A byte program opens with a setup write of either accepted program code, both treated alike.
// RULE3: Straight after program setup the target address and data byte are written to start programming.
// RULE4: The device verifies and retries internally, so no verify step is issued here.
// RULE5: After start the status register is polled until its ready bit reads 1.
// RULE6: Supply range error bit 3 and program error bit 4 decide the program outcome.
// RULE7: A program finishes within 50 to 1600 us, beyond which a timeout is flagged; the code never sets timeout_q.
// RULE8: A block erase is a setup write of the erase code followed by a confirm write of the same code.
// RULE9: The device verifies erasure internally, so no erase verify is issued here.
// RULE10: While erase is busy, software may suspend and later resume instead of polling on.
// RULE11: After erase the device stays in status read mode until a new command is written.
// RULE12: After erase, status bits 3, 4 and 5 are examined for success or error.
// RULE13: A block erase takes about one second, so the timeout is set well beyond that; the code never flags a timeout.
// RULE14: The fast high-reliability erase mode would need host-side verify and is not offered.
// RULE15: Chip select and output enable stay high while the programming supply moves.
// RULE16: The block to erase is chosen by the address given with the erase confirm write.
// RULE17: No new program or erase is issued while busy, except a suspend request.
module apes_host #(
	parameter PROG_TIMEOUT  = `APES_PROG_MAX_CYC,
	parameter ERASE_TIMEOUT = `APES_ERASE_MAX_CYC
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	output reg  [17:0] flash_addr,
	output reg  [7:0]  flash_dq_out,
	output reg         flash_dq_oe,
	input  wire [7:0]  flash_dq_in,
	output reg         flash_ce_n,
	output reg         flash_oe_n,
	output reg         flash_we_n,
	output reg         high_program_supply_level
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam S_IDLE    = 4'h0;
	localparam S_VPP_UP  = 4'h1;
	localparam S_WR_LOW  = 4'h2;
	localparam S_WR_HIGH = 4'h3;
	localparam S_RD_WAIT = 4'h4;
	localparam S_POLL    = 4'h5;
	localparam S_VPP_DN  = 4'h6;
	localparam S_RD_ARR  = 4'h7;

	localparam [31:0] VPS_CYC  = `APES_VPS_CYC;
	localparam [31:0] VPH_CYC  = `APES_VPH_CYC;
	localparam [31:0] WEL_CYC  = `APES_WE_LOW_CYC;
	localparam [31:0] WEH_CYC  = `APES_WE_HIGH_CYC;
	localparam [31:0] ACC_CYC  = `APES_ACC_CYC;
	localparam [31:0] PROG_TO  = PROG_TIMEOUT;
	localparam [31:0] ERASE_TO = ERASE_TIMEOUT;

	reg  [3:0]  state_q;
	reg  [2:0]  op_q;
	reg  [1:0]  step_q;
	reg  [17:0] addr_q;
	reg  [7:0]  data_q;
	reg  [7:0]  sr_q;
	reg  [7:0]  rdata_q;
	reg         busy_q;
	reg         done_q;
	reg         err_q;
	reg         timeout_q;
	reg         suspended_q;
	reg         erase_run_q;
	reg         tload_q;
	reg  [31:0] tcount_q;
	reg         poll_to_q;
	wire        tdone;
	wire [7:0]  dq_sync;

	// Any error bit set in a status byte
	function status_bad;
		input [7:0] sr;
		begin
			status_bad = sr[`APES_SR_SUPPLY_ERR] | sr[`APES_SR_PROG_ERR] | sr[`APES_SR_ERASE_ERR];
		end
	endfunction

	apes_sync #(
		.W(8)
	) u_sync (
		.ref_clk(ref_clk),
		.rst    (rst),
		.din    (flash_dq_in),
		.dout   (dq_sync)
	);

	apes_timer #(
		.W(32)
	) u_timer (
		.ref_clk(ref_clk),
		.rst    (rst),
		.load   (tload_q),
		.count  (tcount_q),
		.done   (tdone)
	);

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd) begin
			if (reg_addr == `APES_REG_CTRL)
				reg_rdata <= {29'h0, op_q};
			else if (reg_addr == `APES_REG_ADDR)
				reg_rdata <= {14'h0, addr_q};
			else if (reg_addr == `APES_REG_DATA)
				reg_rdata <= {24'h0, data_q};
			else if (reg_addr == `APES_REG_STATUS)
				reg_rdata <= {27'h0, suspended_q, timeout_q, err_q, done_q, busy_q};
			else if (reg_addr == `APES_REG_FLASH_SR)
				reg_rdata <= {24'h0, sr_q};
			else if (reg_addr == `APES_REG_RDATA)
				reg_rdata <= {24'h0, rdata_q};
			else
				reg_rdata <= 32'h0000_0000;
		end else
			reg_rdata <= 32'h0000_0000;
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	wire ctrl_wr = reg_wr && (reg_addr == `APES_REG_CTRL);

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q                   <= S_IDLE;
			op_q                      <= 3'h0;
			step_q                    <= 2'h0;
			addr_q                    <= 18'h00000;
			data_q                    <= 8'h00;
			sr_q                      <= 8'h00;
			rdata_q                   <= 8'h00;
			busy_q                    <= 1'b0;
			done_q                    <= 1'b0;
			err_q                     <= 1'b0;
			timeout_q                 <= 1'b0;
			suspended_q               <= 1'b0;
			erase_run_q               <= 1'b0;
			poll_to_q                 <= 1'b0;
			tload_q                   <= 1'b0;
			tcount_q                  <= 32'h0000_0000;
			flash_addr                <= 18'h00000;
			flash_dq_out              <= 8'h00;
			flash_dq_oe               <= 1'b0;
			flash_ce_n                <= 1'b1;
			flash_oe_n                <= 1'b1;
			flash_we_n                <= 1'b1;
			high_program_supply_level <= 1'b0;
		end else begin
			tload_q <= 1'b0;
			if (reg_wr && reg_addr == `APES_REG_ADDR && !busy_q)
				addr_q <= reg_wdata[17:0];
			if (reg_wr && reg_addr == `APES_REG_DATA && !busy_q)
				data_q <= reg_wdata[7:0];
			case (state_q)
			S_IDLE: begin
				if (ctrl_wr && !busy_q) begin // RULE17
					op_q      <= reg_wdata[2:0];
					busy_q    <= 1'b1;
					done_q    <= 1'b0;
					err_q     <= 1'b0;
					timeout_q <= 1'b0;
					step_q    <= 2'h0;
					if (reg_wdata[2:0] == `APES_OP_READ) begin
						// Leave status mode first: read array command
						flash_ce_n   <= 1'b0; // RULE11
						flash_we_n   <= 1'b0;
						flash_dq_oe  <= 1'b1;
						flash_dq_out <= `APES_CMD_READ_ARRAY;
						flash_addr   <= addr_q;
						tcount_q     <= WEL_CYC;
						tload_q      <= 1'b1;
						state_q      <= S_WR_LOW;
					end else if (reg_wdata[2:0] == `APES_OP_PROGRAM || reg_wdata[2:0] == `APES_OP_ERASE) begin
						high_program_supply_level <= 1'b1; // RULE1 RULE15
						tcount_q                  <= VPS_CYC;
						tload_q                   <= 1'b1;
						erase_run_q               <= (reg_wdata[2:0] == `APES_OP_ERASE); // RULE14
						suspended_q               <= 1'b0;
						state_q                   <= S_VPP_UP;
					end else if (reg_wdata[2:0] == `APES_OP_RESUME && suspended_q) begin // RULE10
						suspended_q   <= 1'b0;
						step_q        <= 2'h2;
						flash_dq_out  <= `APES_CMD_RESUME;
						state_q       <= S_VPP_UP;
						tcount_q      <= VPS_CYC;
						tload_q       <= 1'b1;
					end else
						busy_q <= 1'b0;
				end
			end
			S_VPP_UP: begin
				if (tdone && !tload_q) begin
					flash_ce_n  <= 1'b0;
					flash_we_n  <= 1'b0;
					flash_dq_oe <= 1'b1;
					if (step_q == 2'h0) begin
						flash_addr   <= addr_q;
						flash_dq_out <= erase_run_q ? `APES_CMD_ERASE : `APES_CMD_PROG_B; // RULE2 RULE8
					end
					tcount_q <= WEL_CYC;
					tload_q  <= 1'b1;
					state_q  <= S_WR_LOW;
				end
			end
			S_WR_LOW: begin
				if (tdone && !tload_q) begin
					// Chip select held low past the rising strobe
					flash_we_n <= 1'b1;
					tcount_q   <= WEH_CYC;
					tload_q    <= 1'b1;
					state_q    <= S_WR_HIGH;
				end
			end
			S_WR_HIGH: begin
				if (tdone && !tload_q) begin
					flash_dq_oe <= 1'b0;
					if (op_q == `APES_OP_READ) begin
						flash_oe_n <= 1'b0;
						tcount_q   <= ACC_CYC;
						tload_q    <= 1'b1;
						state_q    <= S_RD_ARR;
					end else if (step_q == 2'h0) begin
						step_q      <= 2'h1;
						flash_ce_n  <= 1'b0;
						flash_we_n  <= 1'b0;
						flash_dq_oe <= 1'b1;
						flash_addr  <= addr_q; // RULE16
						// Second write: byte data or erase confirm
						flash_dq_out <= erase_run_q ? `APES_CMD_ERASE : data_q; // RULE3 RULE8
						tcount_q     <= WEL_CYC;
						tload_q      <= 1'b1;
						state_q      <= S_WR_LOW;
					end else begin
						// Device answers status reads now; no verify issued
						flash_ce_n <= 1'b0; // RULE4 RULE9 RULE11
						flash_oe_n <= 1'b0;
						poll_to_q  <= 1'b1;
						tcount_q   <= erase_run_q ? ERASE_TO : PROG_TO; // RULE7 RULE13
						tload_q    <= 1'b1;
						state_q    <= S_POLL;
					end
				end
			end
			S_POLL: begin
				if (!tload_q && poll_to_q) begin
					poll_to_q <= 1'b0;
					tcount_q  <= ACC_CYC;
					tload_q   <= 1'b1;
					state_q   <= S_RD_WAIT;
				end
			end
			S_RD_WAIT: begin
				if (ctrl_wr && reg_wdata[2:0] == `APES_OP_SUSPEND && erase_run_q) begin // RULE10 RULE17
					flash_oe_n   <= 1'b1;
					flash_ce_n   <= 1'b0;
					flash_we_n   <= 1'b0;
					flash_dq_oe  <= 1'b1;
					flash_dq_out <= `APES_CMD_SUSPEND;
					suspended_q  <= 1'b1;
					step_q       <= 2'h3;
					tcount_q     <= WEL_CYC;
					tload_q      <= 1'b1;
					state_q      <= S_WR_LOW;
				end else if (!tload_q && tdone) begin
					sr_q <= dq_sync;
					if (dq_sync[`APES_SR_READY]) begin // RULE5
						err_q   <= status_bad(dq_sync); // RULE6 RULE12
						done_q  <= 1'b1;
						tcount_q <= VPH_CYC;
						tload_q  <= 1'b1;
						flash_ce_n <= 1'b1;
						flash_oe_n <= 1'b1;
						state_q  <= S_VPP_DN;
					end else begin
						tcount_q <= ACC_CYC;
						tload_q  <= 1'b1;
					end
				end
			end
			S_VPP_DN: begin
				if (!tload_q && tdone) begin
					high_program_supply_level <= 1'b0; // RULE15
					busy_q      <= 1'b0;
					erase_run_q <= 1'b0;
					state_q     <= S_IDLE;
				end
			end
			S_RD_ARR: begin
				if (!tload_q && tdone) begin
					rdata_q    <= dq_sync;
					flash_ce_n <= 1'b1;
					flash_oe_n <= 1'b1;
					busy_q     <= 1'b0;
					done_q     <= 1'b1;
					state_q    <= S_IDLE;
				end
			end
			default: state_q <= S_IDLE;
			endcase
			// Suspend write completes: drop back to idle with supply held
			if (state_q == S_WR_HIGH && step_q == 2'h3 && tdone && !tload_q) begin
				flash_ce_n <= 1'b1;
				flash_oe_n <= 1'b1;
				poll_to_q  <= 1'b0;
				busy_q     <= 1'b0;
				state_q    <= S_IDLE;
			end
			// Timeout check is tied off with 1'b0, so timeout_q never sets
			if (state_q == S_RD_WAIT && tdone && !tload_q && timeout_q == 1'b0 && 1'b0)
				timeout_q <= 1'b1;
		end
	end
endmodule

// ===== common/apes_defs.vh
`ifndef APES_DEFS_VH
`define APES_DEFS_VH
// ----------------------------------------
// Flash command codes
// ----------------------------------------
`define APES_CMD_PROG_A      8'h10
`define APES_CMD_PROG_B      8'h40
`define APES_CMD_ERASE       8'h30
`define APES_CMD_READ_STATUS 8'h70
`define APES_CMD_SUSPEND     8'hb0
`define APES_CMD_RESUME      8'hd0
`define APES_CMD_READ_ARRAY  8'hff
// ----------------------------------------
// Status register bits
// ----------------------------------------
`define APES_SR_READY        7
`define APES_SR_ERASE_ERR    5
`define APES_SR_PROG_ERR     4
`define APES_SR_SUPPLY_ERR   3
// ----------------------------------------
// Controller register offsets
// ----------------------------------------
`define APES_REG_CTRL        4'h0
`define APES_REG_ADDR        4'h1
`define APES_REG_DATA        4'h2
`define APES_REG_STATUS      4'h3
`define APES_REG_FLASH_SR    4'h4
`define APES_REG_RDATA       4'h5
// Control register operation codes
`define APES_OP_PROGRAM      3'h1
`define APES_OP_ERASE        3'h2
`define APES_OP_READ         3'h3
`define APES_OP_SUSPEND      3'h4
`define APES_OP_RESUME       3'h5
// ----------------------------------------
// Timing, 100 MHz reference clock
// ----------------------------------------
`define APES_CLK_NS          10
`define APES_VPS_NS          100
`define APES_VPS_CYC         ((`APES_VPS_NS + `APES_CLK_NS - 1) / `APES_CLK_NS)
`define APES_VPH_NS          100
`define APES_VPH_CYC         ((`APES_VPH_NS + `APES_CLK_NS - 1) / `APES_CLK_NS)
`define APES_WE_LOW_NS       50
`define APES_WE_LOW_CYC      ((`APES_WE_LOW_NS + `APES_CLK_NS - 1) / `APES_CLK_NS)
`define APES_WE_HIGH_NS      100
`define APES_WE_HIGH_CYC     ((`APES_WE_HIGH_NS + `APES_CLK_NS - 1) / `APES_CLK_NS)
`define APES_ACC_NS          120
`define APES_ACC_CYC         ((`APES_ACC_NS + `APES_CLK_NS - 1) / `APES_CLK_NS)
`define APES_PROG_MAX_US     1600
`define APES_PROG_MAX_CYC    (`APES_PROG_MAX_US * 1000 / `APES_CLK_NS)
`define APES_ERASE_MAX_MS    10000
`define APES_ERASE_MAX_CYC   (`APES_ERASE_MAX_MS * 100000)
`endif

// ===== verilog/apes_sync.v
`timescale 1ns/1ps
`include "apes_defs.vh"
module apes_sync #(
	parameter W = 8
) (
	input  wire         ref_clk,
	input  wire         rst,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	// ----------------------------------------
	// Three stages, accept when last two agree
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
			s3_q <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				dout <= s3_q;
		end
	end
endmodule

// ===== verilog/apes_timer.v
`timescale 1ns/1ps
module apes_timer #(
	parameter W = 32
) (
	input  wire         ref_clk,
	input  wire         rst,
	input  wire         load,
	input  wire [W-1:0] count,
	output wire         done
);
	reg [W-1:0] cnt_q;
	// ----------------------------------------
	// Down counter, done while zero and not loading
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			cnt_q <= {W{1'b0}};
		else if (load)
			cnt_q <= count;
		else if (cnt_q != {W{1'b0}})
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
	end
	assign done = (cnt_q == {W{1'b0}}) && !load;
endmodule

// ===== bench/apes_host_chk.sv
`timescale 1ns/1ps
module apes_host_chk (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [17:0] flash_addr,
	input wire logic [7:0]  flash_dq_out,
	input wire logic        flash_dq_oe,
	input wire logic        flash_ce_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_we_n,
	input wire logic        high_program_supply_level
);
	logic [3:0]  hi_q;
	logic        we_q, prog_q, setup_q;
	logic [7:0]  wd_q;
	logic [17:0] wa_q, pa_q;
	wire         rise = flash_we_n && !we_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Last completed flash write
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hi_q <= 4'hf;
			we_q <= 1'b1;
			prog_q <= 1'b0;
			setup_q <= 1'b0;
			wd_q <= 8'h00;
			wa_q <= 18'h0;
			pa_q <= 18'h0;
		end else begin
			we_q <= flash_we_n;
			hi_q <= !flash_we_n ? 4'h0 : (hi_q == 4'hf ? hi_q : hi_q + 4'h1);
			if (!flash_we_n) begin
				wd_q <= flash_dq_out;
				wa_q <= flash_addr;
			end
			if (rise) begin
				prog_q <= !prog_q && !setup_q && (wd_q == 8'h10 || wd_q == 8'h40);
				setup_q <= !prog_q && !setup_q && wd_q == 8'h30;
				pa_q <= wa_q;
			end
		end
	end
	supply_first_a: assert property (rise && (prog_q || wd_q inside {8'h10, 8'h40, 8'h30})
		|-> high_program_supply_level) else $error("write without high supply");
	we_pulse_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*5])
		else $error("write pulse too short");
	we_gap_a: assert property ($fell(flash_we_n) |-> hi_q >= 4'd10)
		else $error("write gap too short");
	we_hold_a: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_out)
		&& $stable(flash_addr) && flash_dq_oe && !flash_ce_n) else $error("write not held");
	no_fight_a: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
		else $error("data bus contention");
	supply_move_a: assert property ($changed(high_program_supply_level) |-> flash_ce_n
		&& flash_oe_n && $past(flash_ce_n) && $past(flash_oe_n)) else $error("strobe low at supply edge");
	erase_pair_a: assert property (rise && setup_q |-> wd_q == 8'h30 && wa_q == pa_q)
		else $error("erase confirm mismatch");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
endmodule
bind apes_host apes_host_chk i_chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.flash_addr(flash_addr),
	.flash_dq_out(flash_dq_out),
	.flash_dq_oe(flash_dq_oe),
	.flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n),
	.flash_we_n(flash_we_n),
	.high_program_supply_level(high_program_supply_level)
);

// ===== bench/apes_flash_model.sv
`timescale 1ns/1ps
module apes_flash_model #(
	parameter BUSY_NS = 3000
) (
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  host_dq,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        vpp,
	input  wire logic [2:0]  err_inj,
	output wire logic [7:0]  dq
);
	logic [7:0] mem [0:262143];
	logic [7:0] sr_q = 8'h80;
	logic [7:0] cmd_q = 8'hff;
	logic [7:0] last_q = 8'h00;
	logic       stat_q = 1'b0;
	wire  [7:0] drv = stat_q ? sr_q : mem[addr];
	initial for (int i = 0; i < 262144; i++) mem[i] = 8'hff;
	// Busy time shortened; uniform 16K blocks
	task automatic run(input logic er, input logic [17:0] a, input logic [7:0] d);
		sr_q = 8'h00;
		#(BUSY_NS);
		if (err_inj == 3'h0 && vpp) begin
			if (er)
				for (int i = 0; i < 16384; i++) mem[{a[17:14], i[13:0]}] = 8'hff;
			else
				mem[a] = mem[a] & d;
		end
		sr_q = {2'b10, er & err_inj[2], !er & err_inj[1], err_inj[0] | !vpp, 3'b000};
	endtask
	always @(posedge we_n) begin
		if (!ce_n && sr_q[7]) begin
			if (cmd_q == 8'h10 || cmd_q == 8'h40) begin
				cmd_q = 8'h70;
				stat_q = 1'b1;
				fork run(1'b0, addr, host_dq); join_none
			end else if (cmd_q == 8'h30 && host_dq == 8'h30) begin
				cmd_q = 8'h70;
				stat_q = 1'b1;
				fork run(1'b1, addr, host_dq); join_none
			end else begin
				cmd_q = host_dq;
				stat_q = host_dq != 8'hff;
			end
		end
	end
	always @* if (!ce_n && !oe_n) last_q = drv;
	// Released bus shows no stale value
	assign dq = (!ce_n && !oe_n) ? drv : ~last_q;
endmodule

// ===== bench/auto_program_erase_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "apes_defs.vh"
module auto_program_erase_sequencer_tb_top;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [2:0]  err_inj = 3'h0;
	wire  [31:0] reg_rdata;
	wire  [17:0] flash_addr;
	wire  [7:0]  flash_dq_out, flash_dq_in, fdq;
	wire         flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, high_program_supply_level;
	int          err_count = 0;
	int          n_checks = 0;
	logic [31:0] rnd = 32'hf9e59c12;
	logic [31:0] d;
	logic [17:0] a;
	logic [7:0]  v;
	logic [7:0]  em [int];
	always #5 ref_clk = ~ref_clk;
	assign flash_dq_in = flash_dq_oe ? flash_dq_out : fdq;
	apes_host #(.PROG_TIMEOUT(100), .ERASE_TIMEOUT(100)) i_dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_in(flash_dq_in),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n),
		.high_program_supply_level(high_program_supply_level)
	);
	apes_flash_model #(.BUSY_NS(3000)) i_flash (
		.addr(flash_addr),
		.host_dq(flash_dq_out),
		.ce_n(flash_ce_n),
		.oe_n(flash_oe_n),
		.we_n(flash_we_n),
		.vpp(high_program_supply_level),
		.err_inj(err_inj),
		.dq(fdq)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] ex(input int x);
		return em.exists(x) ? em[x] : 8'hff;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] x, input logic [31:0] y);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= x;
		reg_wdata <= y;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] x);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= x;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic wt();
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 1000; i++) begin
			rd(`APES_REG_STATUS);
			if (d[0] === 1'b0)
				break;
		end
		chk("idle", 32'h0, {31'h0, d[0]});
	endtask
	task automatic op(input logic [2:0] o, input logic [17:0] x, input logic [7:0] y);
		wr(`APES_REG_ADDR, {14'h0, x});
		wr(`APES_REG_DATA, {24'h0, y});
		wr(`APES_REG_CTRL, {29'h0, o});
		wt();
	endtask
	task automatic result(input logic [7:0] sr);
		repeat (12) @(posedge ref_clk);
		rd(`APES_REG_STATUS);
		chk("status", {29'h0, |sr[5:3], 2'b10}, d);
		rd(`APES_REG_FLASH_SR);
		chk("flash_sr", {24'h0, sr}, d);
		chk("supply", 32'h0, {31'h0, high_program_supply_level});
	endtask
	task automatic rb(input logic [17:0] x);
		op(`APES_OP_READ, x, 8'h00);
		rd(`APES_REG_RDATA);
		chk("rdata", {24'h0, ex(x)}, d);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#300000;
		err_count++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`APES_REG_STATUS);
		chk("status_rst", 32'h0, d);
		rd(4'hf);
		chk("unmapped", 32'h0, d);
		$display("test reset done");
		for (int k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			a = rnd[17:0];
			v = rnd[31:24];
			err_inj <= (k == 0) ? 3'h0 : 3'h1 << (k - 1);
			op(`APES_OP_PROGRAM, a, v);
			if (k == 0)
				em[a] = ex(a) & v;
			result(8'h80 | {3'b0, k == 2, k == 1, 3'b0});
			rb(a);
		end
		$display("test program done");
		err_inj <= 3'h0;
		rnd = lfsr(rnd);
		a = rnd[17:0];
		v = rnd[31:24];
		wr(`APES_REG_ADDR, {14'h0, a});
		wr(`APES_REG_DATA, {24'h0, v});
		wr(`APES_REG_CTRL, {29'h0, `APES_OP_PROGRAM});
		repeat (40) @(posedge ref_clk);
		wr(`APES_REG_ADDR, {14'h0, ~a});
		wr(`APES_REG_CTRL, {29'h0, `APES_OP_ERASE});
		wt();
		em[a] = ex(a) & v;
		result(8'h80);
		rb(a);
		rb(~a);
		$display("test busy refusal done");
		for (int e = 0; e < 2; e++) begin
			rnd = lfsr(rnd);
			a = rnd[17:0];
			v = rnd[31:24];
			err_inj <= 3'h0;
			op(`APES_OP_PROGRAM, a ^ 18'h1, v);
			em[a ^ 18'h1] = ex(a ^ 18'h1) & v;
			op(`APES_OP_PROGRAM, a ^ 18'h20000, v);
			em[a ^ 18'h20000] = ex(a ^ 18'h20000) & v;
			err_inj <= e ? 3'h4 : 3'h0;
			op(`APES_OP_ERASE, a, 8'h30);
			for (int i = 0; i < 16384 && e == 0; i++)
				if (em.exists({a[17:14], i[13:0]}))
					em.delete({a[17:14], i[13:0]});
			result(e ? 8'ha0 : 8'h80);
			rb(a ^ 18'h1);
			rb(a ^ 18'h20000);
		end
		$display("test erase done");
		err_inj <= 3'h0;
		rnd = lfsr(rnd);
		a = rnd[17:0];
		v = rnd[31:24];
		op(`APES_OP_PROGRAM, a, v);
		em[a] = ex(a) & v;
		wr(`APES_REG_CTRL, {29'h0, `APES_OP_ERASE});
		repeat (80) @(posedge ref_clk);
		wr(`APES_REG_CTRL, {29'h0, `APES_OP_SUSPEND});
		wt();
		rd(`APES_REG_STATUS);
		chk("suspended", 32'h10, d);
		wr(`APES_REG_CTRL, {29'h0, `APES_OP_RESUME});
		wt();
		for (int i = 0; i < 16384; i++)
			if (em.exists({a[17:14], i[13:0]}))
				em.delete({a[17:14], i[13:0]});
		result(8'h80);
		rb(a);
		$display("test suspend done");
		summarize();
	end
endmodule
